//--- bench/hep_endpoint_assertions.sv
// Concurrent checks on the endpoint block's ports.
// Assumes one clock, ref_clk, and synchronous active-low resetn.
`timescale 1ns/100ps
module hep_endpoint_assertions
  import hep_pkg::*;
(
  input wire logic        ref_clk,           // Block clock.
  input wire logic        resetn,            // Reset, active low.
  input wire logic        psel,              // APB select.
  input wire logic        penable,           // APB enable.
  input wire logic        pwrite,            // APB direction.
  input wire logic [7:0]  paddr,             // APB address.
  input wire logic [31:0] pwdata,            // APB write data.
  input wire logic        pready,            // APB ready.
  input wire logic        pslverr,           // APB error.
  input wire logic        rx_done,           // Packet end pulse.
  input wire logic        rx_late,           // Late data.
  input wire logic        in_validate,       // IN bank validated.
  input wire logic        dma_byte,          // DMA byte taken.
  input wire logic [2:0]  out_hs,            // Handshake code.
  input wire logic        in_zlp,            // ZLP pending.
  input wire logic        dma_active,        // DMA running.
  input wire logic        dma_irq,           // DMA interrupt.
  input wire logic        data_toggle_reset  // Toggle reset pulse.
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // Setup cycle and a control write that asks for a toggle reset.
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_tog_wr;
    psel && penable && pwrite && paddr == HEP_CTL_OFF && pwdata[HEP_C_TOG];
  endsequence

  // Bus timing, handshakes and event causes.
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_ready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_hs_cause: assert property (
    out_hs != HEP_HS_NONE |-> $past(rx_done))
    else $error("handshake without packet");
  a_late_ignored: assert property (
    rx_done && rx_late |=> out_hs == HEP_HS_NONE)
    else $error("late packet answered");
  a_toggle_pulse: assert property (
    s_tog_wr |=> data_toggle_reset ##1 !data_toggle_reset)
    else $error("toggle reset pulse wrong");
  a_toggle_cause: assert property (
    data_toggle_reset |-> $past(psel && penable && pwrite))
    else $error("toggle reset without write");
  a_irq_cause: assert property (
    $rose(dma_irq) |-> $past(dma_byte || rx_done))
    else $error("dma interrupt without cause");
  a_run_stop: assert property (
    $fell(dma_active) |-> $past(dma_byte || rx_done || (psel && pwrite)))
    else $error("dma stopped without cause");
  a_zlp_clear: assert property (
    $fell(in_zlp) |-> $past(in_validate))
    else $error("zlp cleared without validation");
endmodule // hep_endpoint_assertions

//--- bench/hep_host_model.sv
// Behavioural host side: decoded OUT packets, tokens and bus events.
// Assumes ref_clk from the bench; the bench calls the tasks.
`timescale 1ns/100ps
module hep_host_model
  import hep_pkg::*;
(
  input  wire logic        ref_clk,     // Block clock.
  input  wire logic [2:0]  out_hs,      // Handshake from device.
  output logic             rx_done,     // Packet end pulse.
  output logic      [10:0] rx_bytes,    // Payload length.
  output logic             rx_crc_bad,  // CRC failed.
  output logic             rx_late,     // Data after timeout.
  output logic      [1:0]  rx_pid,      // Data PID code.
  output logic             in_token,    // Iso IN token.
  output logic             uframe_end,  // Microframe end.
  output logic             bus_rst_end, // Reset finished.
  output logic             bus_hs       // High-speed reset.
);
  logic [2:0] hs_seen; // Handshake one cycle after the packet.

  // Idle lines; released qualifiers show inverted values.
  initial begin
    {rx_done, in_token, uframe_end, bus_rst_end} = 4'h0;
    {rx_bytes, rx_crc_bad, rx_late, rx_pid, bus_hs} = 16'h0;
  end

  // Sends one OUT packet and samples the answer.
  task automatic pkt(input logic [10:0] n, input logic c, l,
                     input logic [1:0] p);
    @(posedge ref_clk);
    rx_done <= 1'h1;
    {rx_bytes, rx_crc_bad, rx_late, rx_pid} <= {n, c, l, p};
    @(posedge ref_clk);
    rx_done <= 1'h0;
    {rx_bytes, rx_crc_bad, rx_late, rx_pid} <= ~{n, c, l, p};
    @(posedge ref_clk);
    hs_seen = out_hs;
  endtask

  // Pulses token, microframe end or reset end for one cycle.
  task automatic ev(input logic [2:0] m, input logic hs);
    @(posedge ref_clk);
    {bus_rst_end, uframe_end, in_token} <= m;
    bus_hs <= hs;
    @(posedge ref_clk);
    {bus_rst_end, uframe_end, in_token} <= 3'h0;
    bus_hs <= ~hs;
  endtask
endmodule // hep_host_model

//--- bench/testbench.sv
// Self-checking bench for the endpoint block with a host model.
// Assumes the design package and the checker file compile first.
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  bad_count++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  import hep_pkg::*;
  typedef struct packed {
    logic iso; logic [10:0] n; logic c, l; logic [2:0] hs;
    logic [10:0] fl, len;
  } hep_row_s;
  logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, er;
  logic in_validate, dma_byte, rx_done, rx_crc_bad, rx_late, in_token;
  logic uframe_end, bus_rst_end, bus_hs, in_zlp, dma_active, dma_irq;
  logic data_toggle_reset;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [10:0] rx_bytes;
  logic [2:0] out_hs;
  logic [1:0] rx_pid;
  int check_count, bad_count;
  hep_row_s rows [6] = '{
    '{1'h0, 11'h040, 1'h0, 1'h0, HEP_HS_ACK, 11'h001, 11'h040},
    '{1'h0, 11'h000, 1'h0, 1'h0, HEP_HS_ACK, 11'h001, 11'h000},
    '{1'h1, 11'h064, 1'h1, 1'h0, HEP_HS_NONE, 11'h011, 11'h064},
    '{1'h1, 11'h064, 1'h0, 1'h1, HEP_HS_NONE, 11'h000, 11'h000},
    '{1'h1, 11'h44C, 1'h0, 1'h0, HEP_HS_NONE, 11'h021, 11'h400},
    '{1'h1, 11'h000, 1'h0, 1'h0, HEP_HS_NONE, 11'h001, 11'h000}};

  hep_endpoint hep_endpoint_i (.ref_clk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_done,
    .rx_bytes, .rx_crc_bad, .rx_late, .rx_pid, .in_token, .in_validate,
    .uframe_end, .bus_rst_end, .bus_hs, .dma_byte, .out_hs, .in_zlp,
    .dma_active, .dma_irq, .data_toggle_reset);
  hep_host_model hep_host_model_i (.ref_clk, .out_hs, .rx_done, .rx_bytes,
    .rx_crc_bad, .rx_late, .rx_pid, .in_token, .uframe_end, .bus_rst_end,
    .bus_hs);

  // Clock of 8 ns.
  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end

  // One APB transfer; read data and error land in rd and er.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask

  // Short reset, a validation pulse and DMA byte pulses.
  task automatic rst();
    @(posedge ref_clk);
    resetn <= 1'h0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'h1;
  endtask
  task automatic val();
    @(posedge ref_clk);
    in_validate <= 1'h1;
    @(posedge ref_clk);
    in_validate <= 1'h0;
  endtask
  task automatic dmab(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      dma_byte <= 1'h1;
      @(posedge ref_clk);
      dma_byte <= 1'h0;
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog against a hang.
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    summarize();
  end

  // Main sequence: table of packets, then hand-written cases.
  initial begin
    {psel, penable, pwrite, in_validate, dma_byte, resetn} = 6'h0;
    {paddr, pwdata} = 40'h0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'h1;
    apb(1'h0, HEP_CFG_OFF, 32'h0);
    `CHK(rd, 32'h0100_0009)
    `CHK(in_zlp, 1'h1)
    foreach (rows[i]) begin
      rst();
      apb(1'h1, HEP_CTL_OFF, {29'h0, rows[i].iso, 2'h0});
      hep_host_model_i.pkt(rows[i].n, rows[i].c, rows[i].l, 2'h0);
      `CHK(hep_host_model_i.hs_seen, rows[i].hs)
      apb(1'h0, HEP_STA_OFF, 32'h0);
      `CHK(rd[10:0], rows[i].fl)
      `CHK(rd[23:13], rows[i].len)
      apb(1'h1, HEP_CLR_OFF, 32'h7FF);
    end
    rst();
    hep_host_model_i.ev(3'h1, 1'h0);
    apb(1'h0, HEP_STA_OFF, 32'h0);
    `CHK(rd[HEP_S_FLOW], 1'h1)
    apb(1'h1, HEP_CLR_OFF, 32'h7FF);
    apb(1'h1, HEP_CFG_OFF, 32'h0100_000B);
    hep_host_model_i.ev(3'h2, 1'h0);
    val();
    @(posedge ref_clk);
    `CHK(in_zlp, 1'h0)
    hep_host_model_i.ev(3'h1, 1'h0);
    val();
    hep_host_model_i.ev(3'h2, 1'h0);
    apb(1'h0, HEP_STA_OFF, 32'h0);
    `CHK(rd[3:2], 2'h3)
    rst();
    apb(1'h1, HEP_CTL_OFF, 32'h4);
    hep_host_model_i.pkt(11'h010, 1'h0, 1'h0, 2'h3);
    hep_host_model_i.pkt(11'h010, 1'h0, 1'h0, 2'h2);
    hep_host_model_i.pkt(11'h010, 1'h0, 1'h0, 2'h1);
    apb(1'h0, HEP_STA_OFF, 32'h0);
    `CHK({rd[HEP_S_FULL], rd[HEP_S_FLOW]}, 2'h3)
    `CHK({rd[29:28], rd[25:24]}, 4'hE)
    rst();
    apb(1'h1, HEP_CTL_OFF, 32'h1);
    hep_host_model_i.pkt(11'h000, 1'h0, 1'h0, 2'h0);
    apb(1'h0, HEP_STA_OFF, 32'h0);
    `CHK(rd[HEP_S_RXRDY], 1'h0)
    apb(1'h1, HEP_CTL_OFF, 32'h2);
    hep_host_model_i.pkt(11'h008, 1'h0, 1'h0, 2'h0);
    `CHK(hep_host_model_i.hs_seen, HEP_HS_STALL)
    apb(1'h0, HEP_STA_OFF, 32'h0);
    `CHK(rd[HEP_S_STALL], 1'h1)
    apb(1'h1, HEP_CTL_OFF, 32'h6);
    hep_host_model_i.pkt(11'h008, 1'h0, 1'h0, 2'h0);
    `CHK(hep_host_model_i.hs_seen, HEP_HS_NONE)
    apb(1'h1, HEP_CTL_OFF, 32'h8);
    @(posedge ref_clk);
    `CHK(data_toggle_reset, 1'h1)
    hep_host_model_i.ev(3'h4, 1'h1);
    apb(1'h0, HEP_STA_OFF, 32'h0);
    `CHK({rd[30], rd[HEP_S_RSTD]}, 2'h3)
    rst();
    apb(1'h1, HEP_CTL_OFF, 32'h1);
    apb(1'h1, HEP_DMA_OFF, 32'h45);
    @(posedge ref_clk);
    `CHK(dma_active, 1'h1)
    dmab(2);
    repeat (2) @(posedge ref_clk);
    `CHK({dma_irq, dma_active}, 2'h2)
    apb(1'h1, HEP_CLR_OFF, 32'h7FF);
    apb(1'h1, HEP_DMA_OFF, 32'h119);
    hep_host_model_i.pkt(11'h004, 1'h0, 1'h0, 2'h0);
    dmab(4);
    apb(1'h0, HEP_STA_OFF, 32'h0);
    `CHK({rd[HEP_S_TEND], dma_active}, 2'h2)
    apb(1'h0, 8'h1C, 32'h0);
    `CHK({er, rd}, 33'h1_0000_0000)
    summarize();
  end
endmodule // testbench

bind hep_endpoint hep_endpoint_assertions hep_chk_i (.ref_clk, .resetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .rx_done,
  .rx_late, .in_validate, .dma_byte, .out_hs, .in_zlp, .dma_active,
  .dma_irq, .data_toggle_reset);

//--- core/hep_bank_ctr.sv
// Bank occupancy tracker for the OUT endpoint.
// Assumes fill and free pulses on ref_clk from the endpoint core.
`timescale 1ns/100ps
module hep_bank_ctr
  import hep_pkg::*;
(
  input  wire logic       ref_clk,   // Block clock.
  input  wire logic       resetn,    // Synchronous reset, active low.
  input  wire logic [1:0] bank_num,  // Banks allotted.
  input  wire logic       fill,      // A bank was filled.
  input  wire logic       free,      // A bank was emptied.
  output logic      [1:0] busy,      // Occupied bank count.
  output logic      [1:0] cpu_idx,   // Bank the processor reads.
  output logic            full       // Every bank occupied.
);
  typedef struct packed {
    logic [1:0] busy;
    logic [1:0] rd;
  } hep_bk_s;
  hep_bk_s st_reg, st_next;

  // Count up on fill, down on free, rotate the read index on free.
  always_comb begin
    st_next = st_reg;
    if (fill && !free) begin
      st_next.busy = st_reg.busy + 2'h1;
    end else if (free && !fill) begin
      st_next.busy = st_reg.busy - 2'h1;
    end
    if (free) begin
      st_next.rd = (st_reg.rd + 2'h1 >= bank_num) ? 2'h0 : st_reg.rd + 2'h1;
    end
  end

  // State register.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy    = st_reg.busy;
  assign cpu_idx = st_reg.rd;
  assign full    = (st_reg.busy == bank_num);
endmodule // hep_bank_ctr

//--- core/hep_endpoint.sv
// Endpoint core: status flags, OUT reception, iso IN checks, DMA control.
// Assumes a protocol engine on ref_clk delivering decoded token events.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module hep_endpoint
  import hep_pkg::*;
(
  input  wire logic        ref_clk,       // Block clock, 125 MHz.
  input  wire logic        resetn,        // Synchronous reset, active low.
  input  wire logic        psel,          // APB select.
  input  wire logic        penable,       // APB enable.
  input  wire logic        pwrite,        // APB direction.
  input  wire logic [7:0]  paddr,         // APB byte address.
  input  wire logic [31:0] pwdata,        // APB write data.
  output logic      [31:0] prdata,        // APB read data.
  output logic             pready,        // APB ready.
  output logic             pslverr,       // APB error.
  input  wire logic        rx_done,       // OUT packet end pulse.
  input  wire logic [10:0] rx_bytes,      // Received payload length.
  input  wire logic        rx_crc_bad,    // Data CRC failed.
  input  wire logic        rx_late,       // Data came after timeout.
  input  wire logic [1:0]  rx_pid,        // Data PID code of packet.
  input  wire logic        in_token,      // Iso IN token pulse.
  input  wire logic        in_validate,   // Software validated an IN bank.
  input  wire logic        uframe_end,    // Microframe end pulse.
  input  wire logic        bus_rst_end,   // Bus reset finished pulse.
  input  wire logic        bus_hs,        // Reset ended at high speed.
  input  wire logic        dma_byte,      // DMA took one byte.
  output logic [2:0]       out_hs,        // Handshake code for OUT.
  output logic             in_zlp,        // Answer next IN with a ZLP.
  output logic             dma_active,    // DMA channel running.
  output logic             dma_irq,       // DMA event interrupt.
  output logic             data_toggle_reset // Toggle reset pulse.
);

  typedef struct packed {
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic [HEP_S_NUM-1:0] sta;
    logic [3:0]           ctl;
    logic [1:0]           ntr;
    logic [1:0]           nbk;
    logic [10:0]          maxsz;
    logic [4:0]           dctl;
    logic [15:0]          dcount;
    logic [10:0]          rxlen;
    logic [10:0]          left;
    logic [1:0]           pid;
    logic                 speed;
    logic [1:0]           tokens;
    logic [1:0]           valid;
    logic                 sent;
    logic [2:0]           hs;
    logic                 zlp;
    logic                 dirq;
    logic                 tog;
    logic [1:0]           used;
    logic                 tpend;
    logic [HEP_NBANK-1:0][10:0] blen;
    logic [HEP_NBANK-1:0][1:0]  bpid;
  } hep_ep_s;
  hep_ep_s st_reg, st_next;

  logic [1:0] busy;
  logic [1:0] cpu_idx;
  logic       full;
  logic       fill;
  logic       free;
  logic       acc;
  logic       wr;
  logic       rd;
  logic [2:0] idx_sum;
  logic [2:0] idx_wrap;
  logic [1:0] wr_idx;
  logic [1:0] nx_idx;

  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  assign rd  = acc && !pwrite;

  // Bank the next packet fills, and the bank that follows the current one.
  assign idx_sum  = {1'b0, cpu_idx} + {1'b0, busy};
  assign idx_wrap = idx_sum - {1'b0, st_reg.nbk};
  assign wr_idx   = (idx_sum >= {1'b0, st_reg.nbk}) ? idx_wrap[1:0] :
                                                      idx_sum[1:0];
  assign nx_idx   = (cpu_idx + 2'h1 >= st_reg.nbk) ? 2'h0 : cpu_idx + 2'h1;

  // A packet fills a bank unless late, dropped or zero length.
  // A stalled packet is refused and takes no bank either.
  assign fill = rx_done && !rx_late && !full && (rx_bytes != 11'h000) &&
                !(st_reg.ctl[HEP_C_STALL] && !st_reg.ctl[HEP_C_ISO]);
  // A bank frees when its last byte leaves through DMA or data reads.
  assign free = (st_reg.left == 11'h001) &&
                (dma_byte || (rd && paddr == HEP_DATA_OFF));

  hep_bank_ctr u_bank (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .bank_num(st_reg.nbk),
    .fill    (fill),
    .free    (free),
    .busy    (busy),
    .cpu_idx (cpu_idx),
    .full    (full)
  );

  // Next-state logic: bus slave, reception, iso checks, DMA.
  always_comb begin
    logic [HEP_S_NUM-1:0] set;
    logic [HEP_S_NUM-1:0] clr;
    logic [10:0]          len;
    logic                 is_short;
    logic [10:0]          keep;
    set      = '0;
    keep     = 11'h000;
    clr      = '0;
    len      = 11'h000;
    is_short = 1'b0;
    st_next  = st_reg;
    st_next.tog = 1'b0;
    st_next.hs  = HEP_HS_NONE;

    // APB slave answers in the access cycle with zero wait states.
    st_next.pready  = psel && !penable;
    st_next.pslverr = 1'b0;
    st_next.prdata  = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (paddr == HEP_CFG_OFF) begin
        st_next.prdata = {7'h00, st_reg.maxsz, 10'h000,
                          st_reg.nbk, st_reg.ntr};
      end else if (paddr == HEP_CTL_OFF) begin
        st_next.prdata = {28'h0000000, st_reg.ctl};
      end else if (paddr == HEP_STA_OFF) begin
        st_next.prdata = {1'b0, st_reg.speed, st_reg.pid, cpu_idx, busy,
                          st_reg.rxlen, 2'h0, st_reg.sta};
      end else if (paddr == HEP_DMA_OFF) begin
        st_next.prdata = {11'h000, st_reg.dcount, st_reg.dctl};
      end else if (paddr == HEP_DST_OFF) begin
        st_next.prdata = {16'h0000, st_reg.dcount};
      end else if (paddr != HEP_DATA_OFF && paddr != HEP_CLR_OFF) begin
        st_next.pslverr = 1'b1;
      end
    end else if (psel && !penable) begin
      if (paddr > HEP_DATA_OFF || paddr[1:0] != 2'h0) begin
        st_next.pslverr = 1'b1;
      end
    end
    if (wr) begin
      if (paddr == HEP_CFG_OFF) begin
        st_next.ntr   = pwdata[1:0];
        st_next.nbk   = pwdata[3:2];
        st_next.maxsz = pwdata[24:14];
      end else if (paddr == HEP_CTL_OFF) begin
        st_next.ctl = pwdata[3:0];
        // Software resets the toggle after the stall was sent.
        st_next.tog = pwdata[HEP_C_TOG];
      end else if (paddr == HEP_CLR_OFF) begin
        clr = pwdata[HEP_S_NUM-1:0];
      end else if (paddr == HEP_DMA_OFF) begin
        st_next.dctl   = pwdata[4:0];
        st_next.dcount = pwdata[20:5];
      end
    end

    // Byte consumption from the current bank.
    if (dma_byte || (rd && paddr == HEP_DATA_OFF)) begin
      if (st_reg.left != 11'h000) begin
        st_next.left = st_reg.left - 11'h001;
      end
    end
    // The next busy bank becomes current once the current one frees.
    if (free && busy > 2'h1) begin
      st_next.left = st_reg.blen[nx_idx];
      st_next.pid  = st_reg.bpid[nx_idx];
    end
    // Transfer end is reported once DMA has emptied the short packet.
    if (free && dma_byte && st_reg.tpend) begin
      set[HEP_S_TEND] = 1'b1;
      st_next.tpend   = 1'b0;
    end

    // DMA count down, buffer end and stop.
    if (dma_byte && st_reg.dctl[HEP_D_RUN] && st_reg.dcount != 16'h0000) begin
      st_next.dcount = st_reg.dcount - 16'h0001;
      if (st_reg.dcount == 16'h0001) begin
        st_next.dctl[HEP_D_RUN] = 1'b0;
        if (st_reg.dctl[HEP_D_BUFIT]) begin
          set[HEP_S_BUFD] = 1'b1;
        end
      end
    end

    // OUT packet reception.
    if (rx_done && !rx_late) begin
      len = (rx_bytes > st_reg.maxsz) ? st_reg.maxsz : rx_bytes;
      is_short = (rx_bytes < st_reg.maxsz);
      if (st_reg.ctl[HEP_C_STALL] && !st_reg.ctl[HEP_C_ISO]) begin
        st_next.hs = HEP_HS_STALL;
        set[HEP_S_STALL] = 1'b1;
      end else if (full) begin
        if (st_reg.ctl[HEP_C_ISO]) begin
          set[HEP_S_FLOW] = 1'b1;
        end
      end else begin
        st_next.hs    = st_reg.ctl[HEP_C_ISO] ? HEP_HS_NONE : HEP_HS_ACK;
        st_next.rxlen = len;
        keep = len;
        if (!is_short && st_reg.dctl[HEP_D_TRUNC] &&
            st_reg.dcount < {5'h00, len}) begin
          keep = st_reg.dcount[10:0];
        end
        // Each bank keeps its own length and data PID.
        if (fill) begin
          st_next.blen[wr_idx] = keep;
          st_next.bpid[wr_idx] = rx_pid;
        end
        if (busy == 2'h0 || (free && busy == 2'h1)) begin
          st_next.left = keep;
          st_next.pid  = rx_pid;
        end
        // Zero-length with auto commit leaves no visible ready flag.
        if (!(rx_bytes == 11'h000 && st_reg.ctl[HEP_C_AUTO])) begin
          set[HEP_S_RXRDY] = 1'b1;
        end
        if (st_reg.ctl[HEP_C_ISO] && rx_crc_bad) begin
          set[HEP_S_CRC] = 1'b1;
        end
        if (st_reg.ctl[HEP_C_ISO] && rx_bytes > st_reg.maxsz) begin
          set[HEP_S_OVFL] = 1'b1;
        end
        if (is_short && st_reg.dctl[HEP_D_RUN]) begin
          if (st_reg.dctl[HEP_D_SPSTP]) begin
            st_next.dctl[HEP_D_RUN] = 1'b0;
          end
          if (st_reg.dctl[HEP_D_SPIT] && len == 11'h000) begin
            set[HEP_S_TEND] = 1'b1;
          end else if (st_reg.dctl[HEP_D_SPIT]) begin
            st_next.tpend = 1'b1;
          end
        end
      end
    end
    if (fill && busy + 2'h1 == st_reg.nbk) begin
      set[HEP_S_FULL] = 1'b1;
    end

    // Isochronous IN per-microframe accounting.
    if (in_validate && st_reg.valid != 2'h3) begin
      st_next.valid = st_reg.valid + 2'h1;
    end
    if (in_token) begin
      st_next.tokens = st_reg.tokens + 2'h1;
      if (st_reg.valid == st_reg.used) begin
        set[HEP_S_FLOW] = 1'b1;
      end else begin
        st_next.used = st_reg.used + 2'h1;
        st_next.sent = 1'b1;
      end
    end
    // A ZLP is due while no validated bank waits to be sent.
    st_next.zlp = (st_next.valid == st_next.used);
    if (uframe_end) begin
      if (st_reg.sent && st_reg.tokens < st_reg.valid &&
          st_reg.tokens < st_reg.ntr) begin
        set[HEP_S_FLUSH] = 1'b1;
      end
      if (st_reg.sent && st_reg.tokens < st_reg.ntr &&
          st_reg.valid < st_reg.ntr) begin
        set[HEP_S_TRANS] = 1'b1;
      end
      st_next.tokens = 2'h0;
      st_next.valid  = 2'h0;
      st_next.used   = 2'h0;
      st_next.sent   = 1'b0;
      st_next.zlp    = 1'b1;
    end

    // Bus reset end and speed report.
    if (bus_rst_end) begin
      set[HEP_S_RSTD] = 1'b1;
      st_next.speed   = bus_hs;
    end

    // Sticky flags: a set in the same cycle wins over a clear.
    st_next.sta  = (st_reg.sta & ~clr) | set;
    st_next.dirq = st_next.sta[HEP_S_BUFD] | st_next.sta[HEP_S_TEND];
    st_next.sta  = st_next.sta;
  end

  // State register.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_reg       <= '0;
      st_reg.ntr   <= HEP_NTR_RST;
      st_reg.nbk   <= HEP_NBK_RST;
      st_reg.maxsz <= HEP_MAX_RST;
      st_reg.hs    <= HEP_HS_NONE;
      st_reg.zlp   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata            = st_reg.prdata;
  assign pready            = st_reg.pready;
  assign pslverr           = st_reg.pslverr;
  assign out_hs            = st_reg.hs;
  assign in_zlp            = st_reg.zlp;
  assign dma_active        = st_reg.dctl[HEP_D_RUN];
  assign dma_irq           = st_reg.dirq;
  assign data_toggle_reset = st_reg.tog;
endmodule // hep_endpoint

//--- core/hep_pkg.sv
// Constants, register map and types for the endpoint logic block.
// Assumes an APB master on ref_clk and a protocol engine beside it.
package hep_pkg;

  // Register byte offsets.
  localparam logic [7:0] HEP_CFG_OFF  = 8'h00;
  localparam logic [7:0] HEP_CTL_OFF  = 8'h04;
  localparam logic [7:0] HEP_STA_OFF  = 8'h08;
  localparam logic [7:0] HEP_CLR_OFF  = 8'h0C;
  localparam logic [7:0] HEP_DMA_OFF  = 8'h10;
  localparam logic [7:0] HEP_DST_OFF  = 8'h14;
  localparam logic [7:0] HEP_DATA_OFF = 8'h18;

  // Control register bit positions.
  localparam int HEP_C_AUTO  = 0;
  localparam int HEP_C_STALL = 1;
  localparam int HEP_C_ISO   = 2;
  localparam int HEP_C_TOG   = 3;

  // DMA control bit positions.
  localparam int HEP_D_RUN   = 0;
  localparam int HEP_D_TRUNC = 1;
  localparam int HEP_D_BUFIT = 2;
  localparam int HEP_D_SPSTP = 3;
  localparam int HEP_D_SPIT  = 4;

  // Status flag positions (sticky, write one to clear).
  localparam int HEP_S_RXRDY = 0;
  localparam int HEP_S_FLOW  = 1;
  localparam int HEP_S_FLUSH = 2;
  localparam int HEP_S_TRANS = 3;
  localparam int HEP_S_CRC   = 4;
  localparam int HEP_S_OVFL  = 5;
  localparam int HEP_S_STALL = 6;
  localparam int HEP_S_RSTD  = 7;
  localparam int HEP_S_FULL  = 8;
  localparam int HEP_S_BUFD  = 9;
  localparam int HEP_S_TEND  = 10;
  localparam int HEP_S_NUM   = 11;

  // Field sizes and reset values.
  localparam int         HEP_NBANK     = 3;
  localparam logic [1:0] HEP_NTR_RST   = 2'h1;
  localparam logic [1:0] HEP_NBK_RST   = 2'h2;
  localparam logic [10:0] HEP_MAX_RST  = 11'h400;

  // Handshake codes given to the protocol engine.
  typedef enum logic [2:0] {
    HEP_HS_NONE  = 3'b001,
    HEP_HS_ACK   = 3'b010,
    HEP_HS_STALL = 3'b100
  } hep_hs_e;

endpackage
